// file: rtl/adcsp_top.sv
// converter control, parallel and serial result port, axi4-lite registers
// assumes pins are asynchronous and core_result is steady at conversion end
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
module adcsp_top import adcsp_pkg::*; #(
  parameter int DIV = SCLK_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic convert_start_n,
  input wire logic reset_in,
  input wire logic power_down_in,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic sclk_in,
  input wire logic daisy_chain_in,
  input wire logic [RES_W-1:0] core_result,
  output logic [RES_W-1:0] pin_out,
  output logic [RES_W-1:0] pin_oe,
  output logic busy
);
  localparam int CNT_W = $clog2(CAL_CYCLES + 1);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  adcsp_pins_s pin_s;  // synchronised pins
  logic [6:0] sync_q;  // synchronised pins relative to rest levels
  adcsp_pins_s pin_prev_reg;  // previous synchronised pins
  adcsp_ctrl_s ctrl_reg;  // software control
  adcsp_state_e state_reg;  // conversion control
  logic [CNT_W-1:0] cnt_reg;  // conversion or calibration timer
  logic busy_reg;
  logic [RES_W-1:0] result_reg;  // latched result
  logic [RES_W-1:0] sr_reg;  // output shift register
  logic [4:0] bit_reg;  // bits sent
  logic [3:0] div_reg;  // master clock divider
  logic [1:0] phase_reg;  // master clock quarter
  logic m_active_reg;  // master read running
  logic s_active_reg;  // slave read running
  logic s_done_reg;  // slave read finished
  logic err_reg;  // incomplete read pulse
  logic [RES_W-1:0] pin_out_reg;
  logic [RES_W-1:0] pin_oe_reg;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg, wdata_q;
  logic [AXI_ADDR_W-1:0] awaddr_q;
  logic wstrb0_q;

  // synchronise every pin; flops clear to rest level, so reset gives no false edge or enable
  adcsp_sync #(.W(7)) u_sync (
    .clk(aclk),
    .rst_n(aresetn),
    .d({convert_start_n, reset_in, power_down_in, cs_n, rd_n, sclk_in, daisy_chain_in} ^ PIN_IDLE),
    .q(sync_q)
  );
  assign pin_s = sync_q ^ PIN_IDLE;

  // previous values for edge finding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev_reg <= PIN_IDLE;
    end else begin
      pin_prev_reg <= pin_s;
    end
  end

  // decoded modes and events
  logic serial, master, slave, cnv_fall, conv_start, conv_done, s_edge, msclk;
  always_comb begin
    serial = ctrl_reg.mode == MODE_SERIAL;
    master = serial && !ctrl_reg.clock_source_select;
    slave = serial && ctrl_reg.clock_source_select;
    cnv_fall = pin_prev_reg.convert_start_n && !pin_s.convert_start_n;
    // start only when idle and not powered down
    conv_start = state_reg == ST_IDLE && cnv_fall && !pin_s.power_down_in && !pin_s.reset_in; // RULE14 RULE15
    conv_done = state_reg == ST_CONV && cnt_reg == CNT_W'(CONV_CYCLES - 1) && !pin_s.reset_in;
    // active edge picked by polarity, gated by select
    if (ctrl_reg.clock_polarity_invert) begin
      s_edge = pin_prev_reg.sclk && !pin_s.sclk; // RULE2
    end else begin
      s_edge = !pin_prev_reg.sclk && pin_s.sclk; // RULE1
    end
    s_edge = s_edge && !pin_s.cs_n && slave; // RULE11
    // master clock high in the middle quarters, low there when clock_polarity_invert is set
    msclk = (phase_reg[0] ^ phase_reg[1]) ^ ctrl_reg.clock_polarity_invert;
  end

  // conversion, reset and calibration sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end else if (pin_s.reset_in) begin
      // held in reset, any conversion dropped
      state_reg <= ST_RST; // RULE12
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_RST: begin
          // reset released: calibrate with busy high
          state_reg <= ST_CAL; // RULE13
          busy_reg <= 1'b1;
        end
        ST_CAL: begin
          if (cnt_reg == CNT_W'(CAL_CYCLES - 1)) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            busy_reg <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_IDLE: begin
          if (conv_start) begin
            state_reg <= ST_CONV; // RULE15
            busy_reg <= 1'b1; // RULE9
          end
        end
        ST_CONV: begin
          // power-down does not stop a running conversion
          if (conv_done) begin
            state_reg <= ST_IDLE; // RULE14
            cnt_reg <= '0;
            busy_reg <= 1'b0; // RULE9
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // result latch, falls with busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_reg <= '0;
    end else if (conv_done) begin
      result_reg <= core_result; // RULE9
    end
  end

  // serial engine for master and slave reads
  always_ff @(posedge aclk) begin
    if (!aresetn || pin_s.reset_in) begin
      sr_reg <= '0;
      bit_reg <= '0;
      div_reg <= '0;
      phase_reg <= '0;
      m_active_reg <= 1'b0;
      s_active_reg <= 1'b0;
      s_done_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      err_reg <= 1'b0;
      if (master && !m_active_reg && (ctrl_reg.read_during_convert ? conv_start : conv_done)) begin
        // previous result during conversion, else the new one
        sr_reg <= ctrl_reg.read_during_convert ? result_reg : core_result; // RULE18
        m_active_reg <= 1'b1;
        bit_reg <= '0;
        div_reg <= '0;
        phase_reg <= '0;
      end else if (m_active_reg) begin
        if (div_reg == 4'(DIV - 1)) begin
          div_reg <= '0;
          phase_reg <= phase_reg + 2'h1;
          // data moves only between clock pulses
          if (phase_reg == 2'h3) begin
            if (bit_reg == 5'(RES_W - 1)) begin
              m_active_reg <= 1'b0;
            end else begin
              bit_reg <= bit_reg + 5'h1;
              sr_reg <= {sr_reg[RES_W-2:0], 1'b0}; // RULE16 RULE17
            end
          end
        end else begin
          div_reg <= div_reg + 4'h1;
        end
      end else if (slave && conv_done) begin
        if (s_active_reg) begin
          // read cut short: new result lost, flag pulses
          s_active_reg <= 1'b0; // RULE6 RULE21
          err_reg <= 1'b1;
        end else begin
          sr_reg <= core_result;
          s_done_reg <= 1'b0;
        end
      end else if (s_edge) begin
        if (!s_active_reg && !s_done_reg) begin
          // first edge opens the read and shows the msb
          s_active_reg <= 1'b1;
          bit_reg <= 5'h1;
        end else begin
          // chain input follows the 18 result bits
          sr_reg <= {sr_reg[RES_W-2:0], pin_s.daisy_chain_in}; // RULE1 RULE2 RULE17 RULE19
          if (s_active_reg && bit_reg == 5'(RES_W - 1)) begin
            s_active_reg <= 1'b0;
            s_done_reg <= 1'b1;
          end else if (s_active_reg) begin
            bit_reg <= bit_reg + 5'h1;
          end
        end
      end
    end
  end

  // pin drivers, enabled by select and read together
  logic en;
  logic [RES_W-1:0] out_next, oe_next;
  always_comb begin
    en = !pin_s.cs_n && !pin_s.rd_n; // RULE10
    out_next = result_reg; // RULE7
    oe_next = {RES_W{en}}; // RULE8 RULE20
    if (serial) begin
      oe_next[PIN_SCLK:0] = '0;
      out_next[PIN_SCLK:0] = '0;
      out_next[PIN_SDO] = sr_reg[RES_W-1]; // RULE17
      oe_next[PIN_SDO] = en;
      // clock pin is an output only in master
      out_next[PIN_SCLK] = m_active_reg ? msclk : ctrl_reg.clock_polarity_invert; // RULE3
      oe_next[PIN_SCLK] = en && master; // RULE3
      out_next[PIN_SYNC] = (master && m_active_reg) ^ ctrl_reg.frame_sync_polarity; // RULE4 RULE5
      out_next[PIN_ERR] = err_reg; // RULE6
    end
  end

  // registered pin outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_reg <= '0;
      pin_oe_reg <= '0;
    end else begin
      pin_out_reg <= out_next;
      pin_oe_reg <= oe_next;
    end
  end

  // axi write: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
      ctrl_reg <= CTRL_RESET;
    end else begin
      if (awvalid && awready_reg) begin
        awaddr_q <= awaddr;
        awready_reg <= 1'b0;
      end
      if (wvalid && wready_reg) begin
        wdata_q <= wdata;
        wstrb0_q <= wstrb[0];
        wready_reg <= 1'b0;
      end
      if (!awready_reg && !wready_reg && !bvalid_reg) begin
        bvalid_reg <= 1'b1;
        // only the control word is writable
        if (awaddr_q[3:2] == OFF_CTRL[3:2]) begin
          bresp_reg <= RESP_OKAY;
          if (wstrb0_q) begin
            ctrl_reg <= wdata_q[5:0];
          end
        end else begin
          bresp_reg <= RESP_SLVERR;
        end
      end
      if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // axi read: answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
      unique case (araddr[3:2])
        OFF_CTRL[3:2]: rdata_reg[5:0] <= ctrl_reg;
        OFF_STATUS[3:2]: begin
          rdata_reg[STAT_BUSY] <= busy_reg;
          rdata_reg[STAT_CAL] <= state_reg == ST_CAL;
          rdata_reg[STAT_PD] <= pin_s.power_down_in;
          rdata_reg[STAT_READ] <= m_active_reg || s_active_reg;
        end
        OFF_RESULT[3:2]: rdata_reg[RES_W-1:0] <= result_reg;
        default: rresp_reg <= RESP_SLVERR;
      endcase
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;
  assign busy = busy_reg;

  // checks beside the logic
  property p_start_busy;
    conv_start |=> busy_reg && state_reg == ST_CONV;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy not raised on start"); // RULE15
  property p_done_latch;
    conv_done |=> !busy_reg && result_reg == $past(core_result);
  endproperty
  a_done_latch: assert property (p_done_latch) else $error("busy fell without latch"); // RULE9
  property p_rst_hold;
    pin_s.reset_in |=> state_reg == ST_RST && !busy_reg;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset not held"); // RULE12
  property p_cal;
    state_reg == ST_RST && !pin_s.reset_in |=> busy_reg ##1 (busy_reg || pin_s.reset_in);
  endproperty
  a_cal: assert property (p_cal) else $error("no calibration pulse"); // RULE13
  property p_pd;
    state_reg == ST_IDLE && pin_s.power_down_in |=> state_reg != ST_CONV;
  endproperty
  a_pd: assert property (p_pd) else $error("conversion began in power-down"); // RULE14
  property p_err;
    slave && conv_done && s_active_reg |=> err_reg && !s_active_reg ##1 !err_reg;
  endproperty
  a_err: assert property (p_err) else $error("incomplete read not flagged"); // RULE6
  property p_oe;
    pin_oe_reg != '0 |-> $past(!pin_s.cs_n && !pin_s.rd_n);
  endproperty
  a_oe: assert property (p_oe) else $error("driver on without select and read"); // RULE10
  property p_sync;
    serial && master && m_active_reg && $stable(ctrl_reg) |=> pin_out_reg[PIN_SYNC] != $past(ctrl_reg.frame_sync_polarity);
  endproperty
  a_sync: assert property (p_sync) else $error("frame sync wrong level"); // RULE4 RULE5
  property p_mstable;
    m_active_reg && phase_reg != 2'h0 |-> $stable(sr_reg);
  endproperty
  a_mstable: assert property (p_mstable) else $error("master data moved near clock edge"); // RULE16
  property p_sshift;
    s_edge && s_active_reg && !conv_done && !pin_s.reset_in |=>
      sr_reg == {$past(sr_reg[RES_W-2:0]), $past(pin_s.daisy_chain_in)};
  endproperty
  a_sshift: assert property (p_sshift) else $error("slave shift wrong"); // RULE1 RULE2
endmodule

// file: rtl/adcsp_pkg.sv
// constants, carriers and states of the converter control and serial port
// assumes a 20 MHz aclk and an axi4-lite master on the register side
// Overview of operation
// RULE1 - slave, plain clock: data changes on rising
// RULE2 - slave, inverted clock: data changes on falling
// RULE3 - pin 11: parallel bit or serial clock
// RULE4 - master, sync polarity low: sync high while reading
// RULE5 - master, sync polarity high: sync low while reading
// RULE6 - slave read cut by conversion: drop, pulse flag
// RULE7 - parallel modes drive bits 12, 13 there
// RULE8 - bits 14 to 17 always outputs
// RULE9 - busy from start until result latched
// RULE10 - drivers on only while select and read low
// RULE11 - select gates external serial clock in slave
// RULE12 - reset input high holds reset, aborts conversion
// RULE13 - reset falling edge: calibrate, busy pulses high
// RULE14 - power-down: finish current, refuse new conversions
// RULE15 - start falling edge holds sample, starts converting
// RULE16 - master data stable across both clock edges
// RULE17 - result shifted out msb first
// RULE18 - read-during-convert gives previous result, else current
// RULE19 - slave: chain input appears after 18 clocks
// RULE20 - undriven data pins float when not enabled
// RULE21 - host finishes slave read before next result
package adcsp_pkg;
  // timing at the 50 ns aclk
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS = 600;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_TIME_NS = 2000;
  localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_DIV = 2;  // aclk cycles per quarter of master clock
  localparam int RES_W = 18;  // result width
  // register map, byte addresses
  localparam int AXI_ADDR_W = 4;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_RESULT = 4'h8;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // status field positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_CAL = 1;
  localparam int STAT_PD = 2;
  localparam int STAT_READ = 3;
  // interface mode and shared pin positions
  localparam logic [1:0] MODE_SERIAL = 2'h3;
  localparam int PIN_SDO = 10;
  localparam int PIN_SCLK = 11;
  localparam int PIN_SYNC = 12;
  localparam int PIN_ERR = 13;
  // pin levels at rest, in adcsp_pins_s order: start high, selects high
  localparam logic [6:0] PIN_IDLE = 7'h4c;
  // control register layout, bit 5 down to 0
  typedef struct packed {
    logic read_during_convert;
    logic frame_sync_polarity;
    logic clock_polarity_invert;
    logic clock_source_select;
    logic [1:0] mode;
  } adcsp_ctrl_s;
  // input pins after synchronising
  typedef struct packed {
    logic convert_start_n;
    logic reset_in;
    logic power_down_in;
    logic cs_n;
    logic rd_n;
    logic sclk;
    logic daisy_chain_in;
  } adcsp_pins_s;
  // conversion control states
  typedef enum logic [1:0] {ST_IDLE, ST_RST, ST_CAL, ST_CONV} adcsp_state_e;
endpackage

// file: rtl/adcsp_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to clk
module adcsp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;  // first stage, read only by second
  logic [W-1:0] q_reg;  // second stage
  // both stages clear on reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end
  assign q = q_reg;
endmodule

// file: test/adcsp_host.sv
// host model: starts conversions, selects the port and clocks slave reads
// assumes the pin names of adcsp_top; its serial clock is unrelated to aclk
module adcsp_host (
  input wire logic aclk,
  input wire logic sdo,
  output logic convert_start_n,
  output logic cs_n,
  output logic rd_n,
  output logic sclk_in,
  output logic daisy_chain_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins idle: no start, deselected, clock parked low
  initial begin
    convert_start_n = 1'b1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    sclk_in = 1'b0;
    daisy_chain_in = 1'b0;
  end
  // falling edge on start, held long enough for the synchroniser
  task start_conv();
    @(posedge aclk) convert_start_n <= ~convert_start_n;
    repeat (4) @(posedge aclk);
    convert_start_n <= ~convert_start_n;
  endtask
  // select and read strobe together, then let them settle
  task sel(input logic on);
    @(posedge aclk);
    cs_n <= ~on;
    rd_n <= ~on;
    repeat (4) @(posedge aclk);
  endtask
  // park the clock at its inactive level between frames
  task idle(input logic inv);
    #10 sclk_in = inv;
  endtask
  // n periods; each bit taken just before the next active edge
  task read(input int n, input logic inv, input int half, output logic [17:0] got);
    got = '0;
    // host clock moves off the aclk edge
    #10;
    repeat (n) begin
      sclk_in = ~inv;
      daisy_chain_in = ~daisy_chain_in;
      #(half) sclk_in = inv;
      #(half - 1) got = {got[16:0], sdo};
      #1;
    end
  endtask
endmodule

// file: test/tb_top.sv
// self-checking bench of the converter control and serial result port
// assumes adcsp_top with DIV 1 and the host model beside it
module tb_top import adcsp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [3:0] ws = 4'hf;
  logic [31:0] wdata, rdata, v, d;
  logic [1:0] bresp, rresp, r;
  logic convert_start_n, reset_in, power_down_in, cs_n, rd_n, sclk_in, daisy_chain_in, busy, s;
  logic [17:0] core_result, pin_out, pin_oe, got, last, ex;
  logic [31:0] seed = 32'h926a;
  int err_total, comparisons, n, m;
  adcsp_top #(.DIV(1)) i_adcsp_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .convert_start_n(convert_start_n), .reset_in(reset_in),
    .power_down_in(power_down_in), .cs_n(cs_n), .rd_n(rd_n), .sclk_in(sclk_in), .daisy_chain_in(daisy_chain_in),
    .core_result(core_result), .pin_out(pin_out), .pin_oe(pin_oe), .busy(busy));
  // an undriven data pin shows the inverse of the last value
  adcsp_host i_adcsp_host (.aclk(aclk), .sdo(pin_oe[PIN_SDO] ? pin_out[PIN_SDO] : !pin_out[PIN_SDO]),
    .convert_start_n(convert_start_n), .cs_n(cs_n),
    .rd_n(rd_n), .sclk_in(sclk_in), .daisy_chain_in(daisy_chain_in));
  // 50 ns clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // xorshift source of stimulus
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // compare and count
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // verdict and end of run
  task finish_test();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // axi4-lite write: address and data offered together
  task wr(input logic [3:0] a, input logic [31:0] x, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= x;
    wstrb <= ws;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  // axi4-lite read
  task rd(input logic [3:0] a, output logic [31:0] x, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        x = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // cycles busy stays high, 0 if it never rises within lim
  task busy_len(input int lim, output int k);
    k = 0;
    repeat (lim) begin
      @(posedge aclk);
      if (busy === 1'b1) break;
    end
    while (busy === 1'b1 && k < 100) begin
      k++;
      @(posedge aclk);
    end
  endtask
  // one conversion of value x, length checked
  task conv(input logic [17:0] x);
    int k;
    @(posedge aclk) core_result <= x;
    // watch busy from the start edge on, so its first cycle is counted
    fork
      i_adcsp_host.start_conv();
      busy_len(10, k);
    join
    chk("conv_cycles", CONV_CYCLES, k);
    last = x;
  endtask
  // collect master bits as the clock leaves its rest level (rising, or falling when inverted)
  task mon(input logic fsp, input logic inv, output logic [17:0] b, output int c, output int bad);
    logic c0, act;
    c0 = pin_out[PIN_SCLK];
    c = 0;
    bad = 0;
    b = '0;
    repeat (300) begin
      @(posedge aclk);
      act = pin_out[PIN_SYNC] ^ fsp;
      if (act && pin_out[PIN_SCLK] !== c0 && pin_out[PIN_SCLK] === ~inv && c < 18) begin
        b = {b[16:0], pin_out[PIN_SDO]};
        c++;
      end else if (act && pin_out[PIN_SCLK] !== c0 && c > 0 && pin_out[PIN_SDO] !== b[0]) bad++;
      c0 = pin_out[PIN_SCLK];
    end
  endtask
  // cut a hang short
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    finish_test();
  end
  // main sequence
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    {reset_in, power_down_in} = 2'b00;
    core_result = '0;
    last = '0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= ~aresetn;
    // register bus: reset value, read-back, refusals
    rd(OFF_CTRL, d, r);
    chk("ctrl_reset", 0, d);
    v = rnd();
    wr(OFF_CTRL, v, r);
    rd(OFF_CTRL, d, r);
    chk("ctrl_rw", v & 32'h3f, d);
    wr(OFF_CTRL, 0, r);
    // low strobe bit clear: control word left alone
    d = rnd();
    ws = d[3:0] & 4'he;
    wr(OFF_CTRL, 32'h3f, r);
    ws = 4'hf;
    rd(OFF_CTRL, d, r);
    chk("ctrl_strobe", 0, d);
    rd(4'hc, d, r);
    chk("unmapped_resp", RESP_SLVERR, r);
    chk("unmapped_data", 0, d);
    wr(OFF_STATUS, 32'h1, r);
    chk("ro_resp", RESP_SLVERR, r);
    // reset pin aborts a conversion, release calibrates
    i_adcsp_host.start_conv();
    repeat (4) @(posedge aclk);
    reset_in <= ~reset_in;
    repeat (5) @(posedge aclk);
    chk("busy_abort", 0, busy);
    reset_in <= ~reset_in;
    busy_len(10, n);
    chk("cal_cycles", CAL_CYCLES, n);
    // parallel mode: full word on all pins while read
    v = rnd();
    conv(v[17:0]);
    rd(OFF_RESULT, d, r);
    chk("result_reg", v[17:0], d);
    i_adcsp_host.sel(1'b1);
    chk("par_out", v[17:0], pin_out);
    chk("par_oe", 18'h3ffff, pin_oe);
    i_adcsp_host.sel(1'b0);
    chk("par_float", 0, pin_oe);
    // serial master over every polarity and read mode
    for (int k = 0; k < 8; k++) begin
      wr(OFF_CTRL, {26'h0, k[2], k[1], k[0], 1'b0, MODE_SERIAL}, r);
      v = rnd();
      ex = k[2] ? last : v[17:0];
      fork
        conv(v[17:0]);
        mon(k[1], k[0], got, n, m);
      join
      chk("master_bits", ex, got);
      chk("master_count", 18, n);
      chk("master_stable", 0, m);
      chk("sync_idle", k[1], pin_out[PIN_SYNC]);
    end
    i_adcsp_host.sel(1'b1);
    chk("oe_master", 18'h3fc00, pin_oe);
    i_adcsp_host.sel(1'b0);
    // serial slave, both clock polarities, clocks before select ignored
    for (int k = 0; k < 2; k++) begin
      wr(OFF_CTRL, {26'h0, 2'b00, k[0], 1'b1, MODE_SERIAL}, r);
      i_adcsp_host.idle(k[0]);
      v = rnd();
      conv(v[17:0]);
      i_adcsp_host.read(3, k[0], 200, got);
      i_adcsp_host.sel(1'b1);
      chk("oe_slave", 18'h3f400, pin_oe);
      i_adcsp_host.read(18, k[0], 200, got);
      chk("slave_bits", v[17:0], got);
      i_adcsp_host.sel(1'b0);
    end
    // slave read cut short by the next conversion
    wr(OFF_CTRL, {26'h0, 4'b0001, MODE_SERIAL}, r);
    i_adcsp_host.idle(1'b0);
    v = rnd();
    conv(v[17:0]);
    i_adcsp_host.sel(1'b1);
    i_adcsp_host.read(5, 1'b0, 200, got);
    v = rnd();
    s = 1'b0;
    fork
      conv(v[17:0]);
      repeat (40) begin
        @(posedge aclk);
        if (pin_out[PIN_ERR] === 1'b1) s = 1'b1;
      end
    join
    chk("incomplete_flag", 1, s);
    rd(OFF_RESULT, d, r);
    chk("result_after_cut", v[17:0], d);
    i_adcsp_host.sel(1'b0);
    // power-down: current conversion finishes, next one refused
    v = rnd();
    fork
      conv(v[17:0]);
      begin
        repeat (7) @(posedge aclk);
        power_down_in <= ~power_down_in;
      end
    join
    repeat (4) @(posedge aclk);
    i_adcsp_host.start_conv();
    busy_len(10, n);
    chk("pd_refuse", 0, n);
    rd(OFF_STATUS, d, r);
    chk("status_pd", 1, d[STAT_PD]);
    power_down_in <= ~power_down_in;
    finish_test();
  end
endmodule
